// ===== rtl/iprc_reg_bank.sv
// paged indirect register bank holding the two pll state machine resets
// Summary of operation
// RL1: hidden pages are reached only through direct registers 0x40 to 0x42.
// RL2: 0x40 picks page, 0x41 picks offset, a write to 0x42 stores the byte.
// RL3: page 0x10 offset 0x49 bit 4 holds video pll fsm in reset, default 0.
// RL4: page 0x14 offset 0x49 bit 4 holds the link pll state machine in reset.
// RL5: the host writes zeros to bits 3:0 there; bits 7:5 are reserved.
// RL6: while 0x5B bit 5 is zero, a frequency change does not reset link pll.
// RL7: init sequence A clears bit 5 of 0x5B.
// RL8: init sequence A writes 0x02 into register 0x16.
// RL9: sequence B follows a stable video clock, video pll before link pll.
// RL10: video pll reset: 0x10 to 0x40, 0x49 to 0x41, 0x10 then 0x00 to 0x42.
// RL11: link pll reset: 0x14 to 0x40, 0x49 to 0x41, 0x10 then 0x00 to 0x42.
// RL12: the power-down pin is released before video input is applied.
// RL13: sequence B starts at least 1 us after the video clock is stable.
// RL14: register access opens no earlier than 2 ms after power-down goes high.
// RL15: a low pulse of at least 2 ms on power-down hard-resets the device.
`timescale 1ns/10ps
module iprc_reg_bank #(
    parameter int HARD_RESET_CYC = iprc_pkg::HARD_RESET_CYC,
    parameter int ACCESS_READY_CYC = iprc_pkg::ACCESS_READY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic power_down_n_pin,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic freqChangeDetect,
    output logic [7:0] regRdata,
    output logic regReady,
    output logic video_pll_fsm_reset,
    output logic link_pll_fsm_reset,
    output logic linkPllAutoReset,
    output logic [7:0] busFilterCfg
);
    // ==========================================================
    // assertion clock and reset
    default clocking sysClock @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // power-down pin: hard reset and access gating
    logic [21:0] lowCount;
    logic [21:0] highCount;
    logic hardReset;
    logic accessOpen;
    logic [21:0] next_lowCount;
    logic [21:0] next_highCount;
    localparam logic [21:0] LOW_LIMIT = 22'(HARD_RESET_CYC);
    localparam logic [21:0] READY_LIMIT = 22'(ACCESS_READY_CYC);
    assign next_lowCount = power_down_n_pin ? 22'h00_0000 :
        ((lowCount == LOW_LIMIT) ? lowCount : lowCount + 22'h00_0001);
    assign next_highCount = (!power_down_n_pin || hardReset) ? 22'h00_0000 :
        ((highCount == READY_LIMIT) ? highCount : highCount + 22'h00_0001);
    // RL15 hard reset pulse
    // a short glitch low does not wipe the configuration
    assign hardReset = (lowCount == LOW_LIMIT);
    // RL14 access after delay
    assign accessOpen = (highCount == READY_LIMIT) && power_down_n_pin;
    // requests in the wait are dropped, not queued: the host polls regReady
    assign regReady = accessOpen;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowCount <= 22'h00_0000;
            highCount <= 22'h00_0000;
        end else begin
            lowCount <= next_lowCount;
            highCount <= next_highCount;
        end
    end

    // ==========================================================
    // address decode
    logic wrOk;
    logic wrPage;
    logic wrOffset;
    logic wrData;
    logic wrLinkCfg;
    logic wrFilter;
    logic [7:0] pageSel;
    logic [7:0] offsetSel;
    logic hitVideo;
    logic hitLink;
    // RL1 direct access only
    assign wrOk = regWrite && accessOpen;
    assign wrPage = wrOk && (regAddr == iprc_pkg::ADDR_PAGE_SEL);
    assign wrOffset = wrOk && (regAddr == iprc_pkg::ADDR_OFFSET_SEL);
    assign wrData = wrOk && (regAddr == iprc_pkg::ADDR_PAGE_DATA);
    assign wrLinkCfg = wrOk && (regAddr == iprc_pkg::ADDR_LINK_PLL_CFG);
    assign wrFilter = wrOk && (regAddr == iprc_pkg::ADDR_BUS_FILTER);
    // RL2 page and offset steer the data write
    assign hitVideo = (pageSel == iprc_pkg::PAGE_VIDEO_PLL)
        && (offsetSel == iprc_pkg::OFFS_PLL_FSM_CTRL);
    assign hitLink = (pageSel == iprc_pkg::PAGE_LINK_PLL)
        && (offsetSel == iprc_pkg::OFFS_PLL_FSM_CTRL);

    // ==========================================================
    // registers
    logic [7:0] videoCtrl;
    logic [7:0] linkCtrl;
    logic [7:0] linkPllCfg;
    logic [7:0] busFilter;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pageSel <= iprc_pkg::RST_PAGE_SEL;
            offsetSel <= iprc_pkg::RST_OFFSET_SEL;
            videoCtrl <= iprc_pkg::RST_PLL_FSM_CTRL;
            linkCtrl <= iprc_pkg::RST_PLL_FSM_CTRL;
            linkPllCfg <= iprc_pkg::RST_LINK_PLL_CFG;
            busFilter <= iprc_pkg::RST_BUS_FILTER;
        end else if (hardReset) begin
            pageSel <= iprc_pkg::RST_PAGE_SEL;
            offsetSel <= iprc_pkg::RST_OFFSET_SEL;
            videoCtrl <= iprc_pkg::RST_PLL_FSM_CTRL;
            linkCtrl <= iprc_pkg::RST_PLL_FSM_CTRL;
            linkPllCfg <= iprc_pkg::RST_LINK_PLL_CFG;
            busFilter <= iprc_pkg::RST_BUS_FILTER;
        end else begin
            if (wrPage) begin
                pageSel <= regWdata;
            end
            if (wrOffset) begin
                offsetSel <= regWdata;
            end
            // RL3 video pll control store
            if (wrData && hitVideo) begin
                videoCtrl <= regWdata & iprc_pkg::FSM_CTRL_MASK;
            end
            // RL4 link pll control store
            if (wrData && hitLink) begin
                linkCtrl <= regWdata & iprc_pkg::FSM_CTRL_MASK;
            end
            if (wrLinkCfg) begin
                linkPllCfg <= regWdata;
            end
            if (wrFilter) begin
                busFilter <= regWdata;
            end
        end
    end

    // ==========================================================
    // outputs
    // RL3 video reset level
    assign video_pll_fsm_reset = videoCtrl[iprc_pkg::FSM_RESET_BIT];
    assign linkPllAutoReset = linkPllCfg[iprc_pkg::AUTO_RESET_BIT];
    // RL6 auto reset gated by 0x5B bit 5
    // link reset follows the software bit, or a frequency change when enabled
    assign link_pll_fsm_reset = linkCtrl[iprc_pkg::FSM_RESET_BIT]
        || (freqChangeDetect && linkPllAutoReset);
    assign busFilterCfg = busFilter;

    // reserved bits read as zero because only bit 4 is stored
    logic [7:0] rdMux;
    assign rdMux = (regAddr == iprc_pkg::ADDR_PAGE_SEL) ? pageSel :
        (regAddr == iprc_pkg::ADDR_OFFSET_SEL) ? offsetSel :
        (regAddr == iprc_pkg::ADDR_PAGE_DATA && hitVideo) ? videoCtrl :
        (regAddr == iprc_pkg::ADDR_PAGE_DATA && hitLink) ? linkCtrl :
        (regAddr == iprc_pkg::ADDR_LINK_PLL_CFG) ? linkPllCfg :
        (regAddr == iprc_pkg::ADDR_BUS_FILTER) ? busFilter : 8'h00;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead && accessOpen) begin
            regRdata <= rdMux;
        end
    end

    // ==========================================================
    // checks
    // only bit 4 is stored, so every other bit stays clear in both
    logic reservedClear;
    assign reservedClear =
        ((videoCtrl | linkCtrl) & ~iprc_pkg::FSM_CTRL_MASK) == 8'h00;

    sequence s_pick_video;
        wrPage && (regWdata == iprc_pkg::PAGE_VIDEO_PLL);
    endsequence
    sequence s_pick_link;
        wrPage && (regWdata == iprc_pkg::PAGE_LINK_PLL);
    endsequence
    sequence s_pick_fsm_ctrl;
        wrOffset && (regWdata == iprc_pkg::OFFS_PLL_FSM_CTRL);
    endsequence
    sequence s_set_fsm_bit;
        wrData && regWdata[iprc_pkg::FSM_RESET_BIT];
    endsequence

    a_video_store: assert property (wrData && hitVideo && !hardReset // RL3
        |=> video_pll_fsm_reset == $past(regWdata[iprc_pkg::FSM_RESET_BIT]))
        else $error("video reset bit not stored");
    a_link_store: assert property (wrData && hitLink && !hardReset // RL4
        |=> linkCtrl[iprc_pkg::FSM_RESET_BIT]
            == $past(regWdata[iprc_pkg::FSM_RESET_BIT]))
        else $error("link reset bit not stored");
    a_no_auto_reset: assert property (!linkPllAutoReset // RL6
        && !linkCtrl[iprc_pkg::FSM_RESET_BIT] |-> !link_pll_fsm_reset)
        else $error("link pll reset without enable");
    a_link_auto: assert property (linkPllAutoReset && freqChangeDetect // RL6
        |-> link_pll_fsm_reset)
        else $error("frequency change did not reset link pll");
    a_direct_only: assert property (!wrData && !hardReset // RL1
        |=> $stable(videoCtrl) && $stable(linkCtrl))
        else $error("hidden register changed without data write");
    a_page_select: assert property (wrPage && !hardReset // RL2
        |=> pageSel == $past(regWdata))
        else $error("page select not updated");
    // only the two-cycle spacing of back-to-back host writes is covered
    a_video_path: assert property (s_pick_video ##2 s_pick_fsm_ctrl // RL2
        ##2 s_set_fsm_bit |=> video_pll_fsm_reset)
        else $error("indexed write missed video control");
    a_link_path: assert property (s_pick_link ##2 s_pick_fsm_ctrl // RL2
        ##2 s_set_fsm_bit |=> link_pll_fsm_reset)
        else $error("indexed write missed link control");
    a_access_gate: assert property ($rose(power_down_n_pin) // RL14
        |-> !regReady)
        else $error("access open too early");
    a_hard_reset: assert property (hardReset // RL15
        |=> videoCtrl == iprc_pkg::RST_PLL_FSM_CTRL
            && linkCtrl == iprc_pkg::RST_PLL_FSM_CTRL
            && busFilter == iprc_pkg::RST_BUS_FILTER)
        else $error("hard reset left control set");
    a_reserved_zero: assert property (reservedClear) // RL5
        else $error("reserved bits stored");
endmodule : iprc_reg_bank

// ===== rtl/iprc_pkg.sv
// constants for the paged pll reset control block
package iprc_pkg;
    // direct register addresses
    localparam logic [7:0] ADDR_PAGE_SEL = 8'h40;
    localparam logic [7:0] ADDR_OFFSET_SEL = 8'h41;
    localparam logic [7:0] ADDR_PAGE_DATA = 8'h42;
    localparam logic [7:0] ADDR_LINK_PLL_CFG = 8'h5B;
    localparam logic [7:0] ADDR_BUS_FILTER = 8'h16;
    // hidden pages and offset
    localparam logic [7:0] PAGE_VIDEO_PLL = 8'h10;
    localparam logic [7:0] PAGE_LINK_PLL = 8'h14;
    localparam logic [7:0] OFFS_PLL_FSM_CTRL = 8'h49;
    // field positions
    localparam int FSM_RESET_BIT = 4;
    localparam int AUTO_RESET_BIT = 5;
    // reset values and control store mask
    localparam logic [7:0] RST_PLL_FSM_CTRL = 8'h00;
    localparam logic [7:0] RST_PAGE_SEL = 8'h00;
    localparam logic [7:0] RST_OFFSET_SEL = 8'h00;
    localparam logic [7:0] RST_LINK_PLL_CFG = 8'h20;
    localparam logic [7:0] RST_BUS_FILTER = 8'h00;
    localparam logic [7:0] FSM_CTRL_MASK = 8'h10;
    // timing
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int HARD_RESET_US = 2_000;
    localparam int ACCESS_READY_US = 2_000;
    localparam int HARD_RESET_CYC = (HARD_RESET_US * 1_000_000
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACCESS_READY_CYC = (ACCESS_READY_US * 1_000_000
        + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : iprc_pkg

// ===== verification/iprc_host_model.sv
// host controller model driving the direct register access port
`timescale 1ns/10ps
module iprc_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    // ==========================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk_sys);
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk_sys);
        regRead = 1'b0;
        d = regRdata;
    endtask : rd
    // ==========================================
    // init steps
    // auto reset off, filter set
    task automatic seq_a();
        wr(iprc_pkg::ADDR_LINK_PLL_CFG, 8'h00);
        wr(iprc_pkg::ADDR_BUS_FILTER, 8'h02);
    endtask : seq_a
    task automatic sel_pll(input logic [7:0] pg);
        wr(iprc_pkg::ADDR_PAGE_SEL, pg);
        wr(iprc_pkg::ADDR_OFFSET_SEL, iprc_pkg::OFFS_PLL_FSM_CTRL);
    endtask : sel_pll
    task automatic ctrl(input logic on);
        wr(iprc_pkg::ADDR_PAGE_DATA, on ? iprc_pkg::FSM_CTRL_MASK : 8'h00);
    endtask : ctrl
endmodule : iprc_host_model

// ===== verification/indirect_pll_reset_init_tb.sv
// self-checking bench for the paged pll reset control bank
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
    failures++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module indirect_pll_reset_init_tb;
    localparam int RCYC = 8;
    logic clk_sys, rst_n, power_down_n_pin, freqChangeDetect;
    logic regWrite, regRead, regReady, video_pll_fsm_reset;
    logic link_pll_fsm_reset, linkPllAutoReset;
    logic [7:0] regAddr, regWdata, regRdata, busFilterCfg, rdv;
    logic [7:0] pages [2];
    int failures, checks_done;
    iprc_host_model i_host (.clk_sys(clk_sys), .regRdata(regRdata),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata));
    iprc_reg_bank #(.HARD_RESET_CYC(RCYC), .ACCESS_READY_CYC(RCYC)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .power_down_n_pin(power_down_n_pin),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .freqChangeDetect(freqChangeDetect),
        .regRdata(regRdata), .regReady(regReady),
        .video_pll_fsm_reset(video_pll_fsm_reset),
        .link_pll_fsm_reset(link_pll_fsm_reset),
        .linkPllAutoReset(linkPllAutoReset), .busFilterCfg(busFilterCfg));
    always #12.5 clk_sys = ~clk_sys;
    // ==========================================
    // closing and bounded waits
    task automatic stop_test();
        if (failures == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task automatic wait_ready();
        int n;
        n = 0;
        while (regReady !== 1'b1 && n < 4 * RCYC) begin
            @(negedge clk_sys);
            n++;
        end
        if (regReady !== 1'b1) begin
            failures++;
            stop_test();
        end
    endtask : wait_ready
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        stop_test();
    end
    // ==========================================
    // main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        power_down_n_pin = 1'b1;
        freqChangeDetect = 1'b0;
        failures = 0;
        checks_done = 0;
        pages[0] = iprc_pkg::PAGE_VIDEO_PLL;
        pages[1] = iprc_pkg::PAGE_LINK_PLL;
        repeat (8) @(negedge clk_sys);
        `CHK("autoReset", 1'b1, linkPllAutoReset)
        rst_n = 1'b1;
        i_host.wr(iprc_pkg::ADDR_BUS_FILTER, 8'h55);
        `CHK("ready early", 1'b0, regReady)
        wait_ready();
        i_host.rd(iprc_pkg::ADDR_BUS_FILTER, rdv);
        `CHK("early write", 8'h00, rdv)
        i_host.rd(iprc_pkg::ADDR_LINK_PLL_CFG, rdv);
        `CHK("cfg reset", 8'h20, rdv)
        freqChangeDetect = 1'b1;
        #1 `CHK("auto on", 1'b1, link_pll_fsm_reset)
        i_host.seq_a();
        #1 `CHK("filter", 8'h02, busFilterCfg)
        `CHK("auto off", 1'b0, link_pll_fsm_reset)
        `CHK("auto cfg", 1'b0, linkPllAutoReset)
        freqChangeDetect = 1'b0;
        repeat (40) @(negedge clk_sys);
        // video pll first, then link pll
        for (int i = 0; i < 2; i++) begin
            i_host.sel_pll(pages[i]);
            i_host.ctrl(1'b1);
            `CHK("video on", logic'(i == 0), video_pll_fsm_reset)
            `CHK("link on", logic'(i == 1), link_pll_fsm_reset)
            i_host.rd(iprc_pkg::ADDR_PAGE_DATA, rdv);
            `CHK("hidden rd", 8'h10, rdv)
            i_host.ctrl(1'b0);
            `CHK("video off", 1'b0, video_pll_fsm_reset)
            `CHK("link off", 1'b0, link_pll_fsm_reset)
        end
        i_host.sel_pll(8'h12);
        i_host.ctrl(1'b1);
        i_host.sel_pll(iprc_pkg::PAGE_VIDEO_PLL);
        i_host.wr(iprc_pkg::ADDR_OFFSET_SEL, 8'h48);
        i_host.ctrl(1'b1);
        `CHK("no hit", 2'b00, {video_pll_fsm_reset, link_pll_fsm_reset})
        i_host.rd(8'h77, rdv);
        `CHK("unmapped", 8'h00, rdv)
        power_down_n_pin = 1'b0;
        repeat (RCYC + 2) @(negedge clk_sys);
        `CHK("hard rst", 8'h00, busFilterCfg)
        `CHK("ready held", 1'b0, regReady)
        power_down_n_pin = 1'b1;
        wait_ready();
        i_host.rd(iprc_pkg::ADDR_LINK_PLL_CFG, rdv);
        `CHK("cfg after", 8'h20, rdv)
        stop_test();
    end
endmodule : indirect_pll_reset_init_tb
